// >>> verilog/peak_status_pkg.sv
// Package of offsets, field layouts and reset values for the peak and status registers.
package peak_status_pkg;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [15:0] OFS_CURRENT_PEAK = 16'hE500;
   localparam logic [15:0] OFS_VOLTAGE_PEAK = 16'hE501;
   localparam logic [15:0] OFS_STATUS_FIRST = 16'hE502;

   // ----------------------------------------------------------------
   // Field layout
   // ----------------------------------------------------------------
   localparam int PEAK_VALUE_W   = 24;
   localparam int PEAK_PHASE_LSB = 24;
   localparam int STATUS_W       = 13;
   localparam int BIT_HALF_FULL  = 30;

   // Status bit positions.
   localparam int ST_TOTAL_ACT   = 0;
   localparam int ST_FUND_ACT    = 1;
   localparam int ST_TOTAL_REACT = 2;
   localparam int ST_FUND_REACT  = 3;
   localparam int ST_APPARENT    = 4;
   localparam int ST_LINE_DONE   = 5;
   localparam int ST_ACT_FLIP    = 6;
   localparam int ST_SUM1_FLIP   = 9;
   localparam int ST_REACT_FLIP  = 10;

   // Accumulation mode select bits.
   localparam int ACC_ACT_SEL_BIT   = 6;
   localparam int ACC_REACT_SEL_BIT = 7;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [PEAK_VALUE_W-1:0] PEAK_VALUE_RST = 24'h000000;
   localparam logic [2:0]              PEAK_PHASE_RST = 3'h0;
   localparam logic [STATUS_W-1:0]     STATUS_RST     = 13'h0000;
   localparam logic [2:0]              SIGN_RST       = 3'h0;

   // Peak sample from the detector: magnitude and originating phase.
   typedef struct packed {
      logic                    valid;
      logic [PEAK_VALUE_W-1:0] value;
      logic [2:0]              phase;
   } peak_sample_t;

   // Energy accumulators of one kind across the three phases.
   typedef struct packed {
      logic [31:0] a;
      logic [31:0] b;
      logic [31:0] c;
   } energy_trio_t;

   // Signs of total and fundamental power for three phases (1 = negative).
   typedef struct packed {
      logic [2:0] total;
      logic [2:0] fund;
   } sign_pair_t;

   // Register access request: read and write strobes, address and write data.
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [15:0] addr;
      logic [31:0] wdata;
   } reg_req_t;

endpackage : peak_status_pkg

// >>> verilog/peak_hold.sv
// Holds one captured peak value together with its phase flags.
`timescale 1ns/1ns
module peak_hold
   import peak_status_pkg::*;
(
   input  wire logic         clk_sys_i, // System clock.
   input  wire logic         rst_b_i,   // Asynchronous reset, active low.
   input  wire peak_sample_t sample_i,  // Peak from the detector.
   output logic [31:0]       word_o     // Register image.
);

   logic [PEAK_VALUE_W-1:0] value_q;
   logic [PEAK_VALUE_W-1:0] value_d;
   logic [2:0]              phase_q;
   logic [2:0]              phase_d;

   // A valid sample replaces both the value and its phase flags.
   always_comb begin
      value_d = value_q;
      phase_d = phase_q;
      if (sample_i.valid) begin
         value_d = sample_i.value;
         phase_d = sample_i.phase;
      end
   end

   // Registers the peak, cleared to zero at reset.
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         value_q <= PEAK_VALUE_RST;
         phase_q <= PEAK_PHASE_RST;
      end else begin
         value_q <= value_d;
         phase_q <= phase_d;
      end
   end

   // Upper five bits always read as zero.
   assign word_o = {5'h00, phase_q, value_q};

   a_peak_load: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      sample_i.valid |=> word_o == {5'h00, $past(sample_i.phase), $past(sample_i.value)})
      else $error("Peak register did not take the sample.");

endmodule // peak_hold

// >>> verilog/sign_flip_detect.sv
// Detects sign changes on a group of power signs.
`timescale 1ns/1ns
module sign_flip_detect #(
   parameter int W = 3
) (
   input  wire logic         clk_sys_i, // System clock.
   input  wire logic         rst_b_i,   // Asynchronous reset, active low.
   input  wire logic [W-1:0] sign_i,    // Current signs, 1 = negative.
   output logic [W-1:0]      sign_o,    // Registered signs.
   output logic [W-1:0]      flip_o     // Pulse on each sign change.
);

   logic [W-1:0] sign_q;
   logic [W-1:0] sign_d;

   // Tracks the latest sign.
   always_comb begin
      sign_d = sign_i;
   end

   // Registers the sign; it resets to positive.
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sign_q <= '0;
      end else begin
         sign_q <= sign_d;
      end
   end

   assign sign_o = sign_q;
   assign flip_o = sign_q ^ sign_i;

endmodule // sign_flip_detect

// >>> verilog/peak_status_regs.sv
// Peak capture registers and first event status register of the metering engine.
`timescale 1ns/1ns

// What this block does
// - Current peak value in bits 23:0.
// - Current peak phase A/B/C in bits 24-26.
// - Voltage peak value in bits 23:0.
// - Voltage peak phase A/B/C in bits 24-26.
// - Peak register bits 31:27 read zero.
// - Status bit 0: total active bit30 change.
// - Status bit 1: fundamental active bit30 change.
// - Status bit 2: total reactive bit30 change.
// - Status bit 3: fundamental reactive bit30 change.
// - Status bit 4: apparent energy bit30 change.
// - Status bit 5: line-cycle integration finished.
// - Bits 6-8: active sign flip, selectable source.
// - Bit 9: pulse one sum sign flip.
// - Bits 10-12: reactive sign flip, selectable source.
// - Status flags reset to zero.
// - Status bits 31:13 always read zero.
module peak_status_regs
   import peak_status_pkg::*;
(
   input  wire logic         clk_sys_i,         // System clock, 50 MHz.
   input  wire logic         rst_b_i,           // Asynchronous reset, active low.
   input  wire reg_req_t     req_i,             // Register access request.
   output logic [31:0]       rdata_o,           // Read data, one cycle after rd.
   output logic              rvalid_o,          // Read data valid pulse.
   input  wire peak_sample_t current_peak_i,    // Current channel peak sample.
   input  wire peak_sample_t voltage_peak_i,    // Voltage channel peak sample.
   input  wire energy_trio_t total_active_i,    // Total active accumulators.
   input  wire energy_trio_t fund_active_i,     // Fundamental active accumulators.
   input  wire energy_trio_t total_reactive_i,  // Total reactive accumulators.
   input  wire energy_trio_t fund_reactive_i,   // Fundamental reactive accumulators.
   input  wire energy_trio_t apparent_i,        // Apparent accumulators.
   input  wire logic         line_cycle_mode_i, // Line-cycle accumulation active.
   input  wire logic         line_cycle_end_i,  // Integration over half cycles done.
   input  wire logic [7:0]   accumulation_mode_reg_i, // Accumulation mode register.
   input  wire sign_pair_t   active_sign_i,     // Active power signs.
   input  wire sign_pair_t   reactive_sign_i,   // Reactive power signs.
   input  wire logic         pulse1_sum_sign_i, // Sign of pulse one sum.
   output logic [31:0]       event_status_o,    // Status register image.
   output logic [6:0]        power_sign_reg_o   // Sign register bits 6:0.
);

   // Every check runs on the system clock and rests while reset is applied.
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);

   // ----------------------------------------------------------------
   // Peak capture
   // ----------------------------------------------------------------
   logic [31:0] current_word;
   logic [31:0] voltage_word;

   // Current channel peak with its phase flags.
   peak_hold u_current_peak (
      .clk_sys_i (clk_sys_i),
      .rst_b_i   (rst_b_i),
      .sample_i  (current_peak_i),
      .word_o    (current_word)
   );

   // Voltage channel peak with its phase flags.
   peak_hold u_voltage_peak (
      .clk_sys_i (clk_sys_i),
      .rst_b_i   (rst_b_i),
      .sample_i  (voltage_peak_i),
      .word_o    (voltage_word)
   );

   // ----------------------------------------------------------------
   // Accumulator bit 30 watch
   // ----------------------------------------------------------------
   logic [14:0] half_q;
   logic [14:0] half_d;
   logic [14:0] half_now;

   // Gathers bit 30 of all fifteen accumulators.
   always_comb begin
      half_now = {apparent_i.c[BIT_HALF_FULL], apparent_i.b[BIT_HALF_FULL],
                  apparent_i.a[BIT_HALF_FULL],
                  fund_reactive_i.c[BIT_HALF_FULL], fund_reactive_i.b[BIT_HALF_FULL],
                  fund_reactive_i.a[BIT_HALF_FULL],
                  total_reactive_i.c[BIT_HALF_FULL], total_reactive_i.b[BIT_HALF_FULL],
                  total_reactive_i.a[BIT_HALF_FULL],
                  fund_active_i.c[BIT_HALF_FULL], fund_active_i.b[BIT_HALF_FULL],
                  fund_active_i.a[BIT_HALF_FULL],
                  total_active_i.c[BIT_HALF_FULL], total_active_i.b[BIT_HALF_FULL],
                  total_active_i.a[BIT_HALF_FULL]};
      half_d = half_now;
   end

   // Holds last seen bit 30 values; accumulators are zero after reset.
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         half_q <= 15'h0000;
      end else begin
         half_q <= half_d;
      end
   end

   logic [14:0] half_change;
   assign half_change = half_q ^ half_now;

   // ----------------------------------------------------------------
   // Sign tracking
   // ----------------------------------------------------------------
   logic [2:0] act_sel_sign;
   logic [2:0] react_sel_sign;
   logic [6:0] sign_now;
   logic [6:0] sign_reg;
   logic [6:0] sign_flip;

   // Picks total or fundamental sign by the accumulation mode bits.
   always_comb begin
      act_sel_sign   = accumulation_mode_reg_i[ACC_ACT_SEL_BIT] ?
                       active_sign_i.fund : active_sign_i.total;
      react_sel_sign = accumulation_mode_reg_i[ACC_REACT_SEL_BIT] ?
                       reactive_sign_i.fund : reactive_sign_i.total;
      sign_now       = {react_sel_sign, pulse1_sum_sign_i, act_sel_sign};
   end

   // One detector covers all seven signs in sign-register order.
   sign_flip_detect #(
      .W (7)
   ) u_sign_flip (
      .clk_sys_i (clk_sys_i),
      .rst_b_i   (rst_b_i),
      .sign_i    (sign_now),
      .sign_o    (sign_reg),
      .flip_o    (sign_flip)
   );

   // ----------------------------------------------------------------
   // Event status register
   // ----------------------------------------------------------------
   logic [STATUS_W-1:0] status_q;
   logic [STATUS_W-1:0] status_d;
   logic [STATUS_W-1:0] status_set;
   logic [STATUS_W-1:0] status_clr;

   // Builds set and clear masks; a set in the same cycle beats the clear.
   always_comb begin
      status_set                 = '0;
      status_set[ST_TOTAL_ACT]   = |half_change[2:0];
      status_set[ST_FUND_ACT]    = |half_change[5:3];
      status_set[ST_TOTAL_REACT] = |half_change[8:6];
      status_set[ST_FUND_REACT]  = |half_change[11:9];
      status_set[ST_APPARENT]    = |half_change[14:12];
      status_set[ST_LINE_DONE]   = line_cycle_mode_i & line_cycle_end_i;
      status_set[ST_ACT_FLIP+2:ST_ACT_FLIP]     = sign_flip[2:0];
      status_set[ST_SUM1_FLIP]                  = sign_flip[3];
      status_set[ST_REACT_FLIP+2:ST_REACT_FLIP] = sign_flip[6:4];
      status_clr = '0;
      if (req_i.wr && req_i.addr == OFS_STATUS_FIRST) begin
         status_clr = req_i.wdata[STATUS_W-1:0];
      end
      status_d = (status_q & ~status_clr) | status_set;
   end

   // Registers the flags; all clear at reset.
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         status_q <= STATUS_RST;
      end else begin
         status_q <= status_d;
      end
   end

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic        rvalid_q;
   logic        rvalid_d;

   // Address decode; unmapped offsets read as zero.
   always_comb begin
      rvalid_d = req_i.rd;
      rdata_d  = 32'h00000000;
      if (!req_i.rd) begin
         rdata_d = rdata_q;
      end else if (req_i.addr == OFS_CURRENT_PEAK) begin
         rdata_d = current_word;
      end else if (req_i.addr == OFS_VOLTAGE_PEAK) begin
         rdata_d = voltage_word;
      end else if (req_i.addr == OFS_STATUS_FIRST) begin
         rdata_d = {19'h00000, status_q};
      end
   end

   // Registers the read answer and its valid pulse.
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_q  <= 32'h00000000;
         rvalid_q <= 1'b0;
      end else begin
         rdata_q  <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   assign rdata_o          = rdata_q;
   assign rvalid_o         = rvalid_q;
   assign event_status_o   = {19'h00000, status_q};
   assign power_sign_reg_o = sign_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_total_act_set: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (total_active_i.a[30] != $past(total_active_i.a[30])) |=> status_q[0])
      else $error("Total active half flag not set.");
   a_fund_act_set: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (fund_active_i.b[30] != $past(fund_active_i.b[30])) |=> status_q[1])
      else $error("Fundamental active half flag not set.");
   a_total_react_set: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (total_reactive_i.c[30] != $past(total_reactive_i.c[30])) |=> status_q[2])
      else $error("Total reactive half flag not set.");
   a_fund_react_set: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (fund_reactive_i.a[30] != $past(fund_reactive_i.a[30])) |=> status_q[3])
      else $error("Fundamental reactive half flag not set.");
   a_apparent_set: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (apparent_i.b[30] != $past(apparent_i.b[30])) |=> status_q[4])
      else $error("Apparent half flag not set.");
   a_line_done_set: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      !line_cycle_mode_i && !status_q[ST_LINE_DONE] |=> !status_q[ST_LINE_DONE])
      else $error("Line done flag set outside line-cycle mode.");
   a_sum1_flip: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      $changed(pulse1_sum_sign_i) |=> status_q[9] && sign_reg[3] == $past(pulse1_sum_sign_i))
      else $error("Pulse one sum flip not reported.");
   a_act_flip_sel: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      ##1 $stable(accumulation_mode_reg_i[6]) && accumulation_mode_reg_i[6]
      && $changed(active_sign_i.fund[0]) |=> status_q[6])
      else $error("Active phase A flip not reported.");
   a_react_flip_c: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      ##1 $stable(accumulation_mode_reg_i[7]) && !accumulation_mode_reg_i[7]
      && $changed(reactive_sign_i.total[2]) |=> status_q[12])
      else $error("Reactive phase C flip not reported.");
   a_clear_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      req_i.wr && req_i.addr == OFS_STATUS_FIRST && req_i.wdata[0] && status_set[0] == 1'b0
      |=> !status_q[0])
      else $error("Write one did not clear flag.");
   a_set_wins: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      total_active_i.a[BIT_HALF_FULL] != $past(total_active_i.a[BIT_HALF_FULL])
      && req_i.wr && req_i.addr == OFS_STATUS_FIRST && req_i.wdata[ST_TOTAL_ACT]
      |=> status_q[ST_TOTAL_ACT])
      else $error("Clear beat a new event.");
   a_status_upper: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      rvalid_o && $past(req_i.addr) == OFS_STATUS_FIRST |-> rdata_o[31:19] == 13'h0000)
      else $error("Status upper bits not zero.");

   // ----------------------------------------------------------------
   // Read answers, held peaks and the remaining phases
   // ----------------------------------------------------------------
   a_current_read: assert property (req_i.rd && req_i.addr == OFS_CURRENT_PEAK
      |=> rvalid_o && rdata_o == $past(current_word))
      else $error("Current peak read wrong.");
   a_voltage_read: assert property (req_i.rd && req_i.addr == OFS_VOLTAGE_PEAK
      |=> rvalid_o && rdata_o == $past(voltage_word))
      else $error("Voltage peak read wrong.");
   a_peak_upper: assert property (rvalid_o && $past(req_i.addr) != OFS_STATUS_FIRST
      |-> rdata_o[31:27] == 5'h00)
      else $error("Peak upper bits not zero.");
   a_current_hold: assert property (!current_peak_i.valid
      |=> $stable(current_word))
      else $error("Current peak moved without a sample.");
   a_voltage_hold: assert property (!voltage_peak_i.valid
      |=> $stable(voltage_word))
      else $error("Voltage peak moved without a sample.");
   a_status_read: assert property (req_i.rd && req_i.addr == OFS_STATUS_FIRST
      |=> rdata_o == {19'h00000, $past(status_q)})
      else $error("Status read wrong.");
   a_total_act_b: assert property (total_active_i.b[BIT_HALF_FULL]
      != $past(total_active_i.b[BIT_HALF_FULL]) |=> status_q[ST_TOTAL_ACT])
      else $error("Total active phase B flag not set.");
   a_total_act_quiet: assert property ($stable(total_active_i.a[BIT_HALF_FULL])
      && $stable(total_active_i.b[BIT_HALF_FULL]) && $stable(total_active_i.c[BIT_HALF_FULL])
      && !status_q[ST_TOTAL_ACT] |=> !status_q[ST_TOTAL_ACT])
      else $error("Total active flag set without a change.");
   a_fund_act_c: assert property (fund_active_i.c[BIT_HALF_FULL]
      != $past(fund_active_i.c[BIT_HALF_FULL]) |=> status_q[ST_FUND_ACT])
      else $error("Fundamental active phase C flag not set.");
   a_total_react_a: assert property (total_reactive_i.a[BIT_HALF_FULL]
      != $past(total_reactive_i.a[BIT_HALF_FULL]) |=> status_q[ST_TOTAL_REACT])
      else $error("Total reactive phase A flag not set.");
   a_fund_react_b: assert property (fund_reactive_i.b[BIT_HALF_FULL]
      != $past(fund_reactive_i.b[BIT_HALF_FULL]) |=> status_q[ST_FUND_REACT])
      else $error("Fundamental reactive phase B flag not set.");
   a_apparent_c: assert property (apparent_i.c[BIT_HALF_FULL]
      != $past(apparent_i.c[BIT_HALF_FULL]) |=> status_q[ST_APPARENT])
      else $error("Apparent phase C flag not set.");
   a_line_done_hit: assert property (line_cycle_mode_i && line_cycle_end_i
      |=> status_q[ST_LINE_DONE])
      else $error("Line done flag not set.");
   a_act_sign_fund: assert property (accumulation_mode_reg_i[ACC_ACT_SEL_BIT]
      |=> power_sign_reg_o[2:0] == $past(active_sign_i.fund))
      else $error("Active signs not from the fundamental source.");
   a_react_sign_total: assert property (!accumulation_mode_reg_i[ACC_REACT_SEL_BIT]
      |=> power_sign_reg_o[6:4] == $past(reactive_sign_i.total))
      else $error("Reactive signs not from the total source.");
   a_react_flip_a: assert property ($stable(accumulation_mode_reg_i[ACC_REACT_SEL_BIT])
      && accumulation_mode_reg_i[ACC_REACT_SEL_BIT] && $changed(reactive_sign_i.fund[0])
      |=> status_q[ST_REACT_FLIP])
      else $error("Reactive phase A flip not reported.");
   a_sum1_quiet: assert property ($stable(pulse1_sum_sign_i) && !status_q[ST_SUM1_FLIP]
      |=> !status_q[ST_SUM1_FLIP])
      else $error("Pulse one flag set without a flip.");
   a_clear_keep: assert property (req_i.wr && req_i.addr == OFS_STATUS_FIRST
      && !req_i.wdata[ST_TOTAL_REACT] && status_q[ST_TOTAL_REACT] |=> status_q[ST_TOTAL_REACT])
      else $error("Writing zero cleared a flag.");

endmodule // peak_status_regs

// >>> verification/reg_host_model.sv
// Host model that drives single-cycle reads and writes on the register port.
`timescale 1ns/1ns
module reg_host_model
   import peak_status_pkg::*;
(
   input  wire logic        clk_sys_i, // System clock.
   output reg_req_t         req_o,     // Request towards the register block.
   input  wire logic [31:0] rdata_i,   // Read data.
   input  wire logic        rvalid_i   // Read data valid.
);
   // Strobes start low; address and data start at a neutral pattern.
   initial req_o = '{rd: 1'b0, wr: 1'b0, addr: 16'hFFFF, wdata: 32'h0};

   // Drops the strobes and scrambles address and data, so no stale value can pass.
   task automatic idle();
      req_o.rd    = 1'b0;
      req_o.wr    = 1'b0;
      req_o.addr  = ~req_o.addr;
      req_o.wdata = ~req_o.wdata;
   endtask

   // Writes one word in one cycle; a one in a status bit clears that flag.
   task automatic write(input logic [15:0] a, input logic [31:0] d);
      @(negedge clk_sys_i);
      req_o = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(negedge clk_sys_i);
      idle();
   endtask

   // Reads one word and takes the data in the cycle where the valid pulse stands.
   task automatic read(input logic [15:0] a, output logic [31:0] d);
      d = 'x;
      @(negedge clk_sys_i);
      req_o = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: req_o.wdata};
      for (int i = 0; i < 3; i++) begin
         @(posedge clk_sys_i);
         #1;
         if (rvalid_i === 1'b1) begin
            d = rdata_i;
            break;
         end
      end
      @(negedge clk_sys_i);
      idle();
   endtask
endmodule // reg_host_model

// >>> verification/test_peak_and_status_flag_registers.sv
// Self-checking bench for the peak capture and first event status registers.
`timescale 1ns/1ns
module test_peak_and_status_flag_registers;
   import peak_status_pkg::*;
   logic         clk_sys_i = 1'b0;
   logic         rst_b_i   = 1'b0;
   reg_req_t     req;
   logic [31:0]  rdata, status, rd_v;
   logic         rvalid;
   peak_sample_t cpk = '0, vpk = '0;
   energy_trio_t en [5];
   logic         lc_mode = 1'b0, lc_end = 1'b0, sum1 = 1'b0;
   logic [7:0]   acc = 8'h00;
   sign_pair_t   asg = '0, rsg = '0;
   logic [6:0]   sgn;
   int           errors = 0, n_checks = 0;

   // 50 MHz system clock.
   always #10 clk_sys_i = ~clk_sys_i;

   peak_status_regs uut (
      .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .req_i(req), .rdata_o(rdata),
      .rvalid_o(rvalid), .current_peak_i(cpk), .voltage_peak_i(vpk),
      .total_active_i(en[0]), .fund_active_i(en[1]), .total_reactive_i(en[2]),
      .fund_reactive_i(en[3]), .apparent_i(en[4]), .line_cycle_mode_i(lc_mode),
      .line_cycle_end_i(lc_end), .accumulation_mode_reg_i(acc),
      .active_sign_i(asg), .reactive_sign_i(rsg), .pulse1_sum_sign_i(sum1),
      .event_status_o(status), .power_sign_reg_o(sgn));

   reg_host_model host (.clk_sys_i(clk_sys_i), .req_o(req), .rdata_i(rdata),
      .rvalid_i(rvalid));

   // Counts a comparison and reports it when it differs.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Expected peak word: upper bits zero, phase flags, then the magnitude.
   function automatic logic [31:0] peak_word(input logic [2:0] ph, input logic [23:0] v);
      return {5'h00, ph, v};
   endfunction

   // Expected flags of one phase flip in both power kinds and the pulse one sum.
   function automatic logic [31:0] flip_word(input int p);
      return 32'h1 << (ST_ACT_FLIP + p) | 32'h1 << (ST_REACT_FLIP + p) | 32'h1 << ST_SUM1_FLIP;
   endfunction

   // Prints the verdict and ends the run.
   task automatic tally_and_finish();
      if (errors == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // Reads a register over the port and compares it.
   task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
      host.read(a, rd_v);
      chk(rd_v, e);
   endtask

   // Compares the status register both as read and as the image output.
   task automatic st_chk(input logic [31:0] e);
      rd_chk(OFS_STATUS_FIRST, e);
      chk(status, e);
   endtask

   // Lets an input change reach the flags.
   task automatic settle();
      repeat (2) @(negedge clk_sys_i);
   endtask

   // Clears every status flag.
   task automatic clr();
      host.write(OFS_STATUS_FIRST, 32'hFFFF_FFFF);
   endtask

   // Watchdog sized well above the length of the sequence.
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      errors++;
      tally_and_finish();
   end

   // Main sequence.
   initial begin
      logic [23:0] v;
      logic [2:0]  ph;
      for (int k = 0; k < 5; k++) en[k] = '0;
      void'($urandom(32'h1BFF));
      repeat (8) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      rst_b_i = 1'b1;
      // Reset values, and an unmapped word that reads zero.
      for (int i = 0; i < 4; i++) rd_chk(OFS_CURRENT_PEAK + 16'(i), 32'h0);
      // Peak capture with phase flags; writes to the peak words are ignored.
      for (int i = 0; i < 6; i++) begin
         v  = (i == 0) ? 24'hFFFFFF : 24'($urandom);
         ph = 3'h1 << (i % 3);
         @(negedge clk_sys_i);
         cpk = '{valid: 1'b1, value: v, phase: ph};
         vpk = '{valid: 1'b1, value: ~v, phase: {ph[0], ph[2:1]}};
         @(negedge clk_sys_i);
         cpk = '{valid: 1'b0, value: 24'($urandom), phase: 3'h7};
         vpk.valid = 1'b0;
         host.write(OFS_CURRENT_PEAK, 32'hFFFF_FFFF);
         host.write(OFS_VOLTAGE_PEAK, 32'hFFFF_FFFF);
         rd_chk(OFS_CURRENT_PEAK, peak_word(ph, v));
         rd_chk(OFS_VOLTAGE_PEAK, peak_word({ph[0], ph[2:1]}, ~v));
      end
      // Bit 30 of each accumulator of each kind; other bits must not flag.
      for (int k = 0; k < 5; k++) begin
         for (int p = 0; p < 3; p++) begin
            en[k][(2-p)*32 +: 30] = 30'($urandom);
            en[k][(2-p)*32+31] = ~en[k][(2-p)*32+31];
            settle();
            st_chk(32'h0);
            en[k][(2-p)*32+30] = ~en[k][(2-p)*32+30];
            settle();
            st_chk(32'h1 << k);
            host.write(OFS_STATUS_FIRST, ~(32'h1 << k));
            st_chk(32'h1 << k);
            host.write(OFS_STATUS_FIRST, 32'h1 << k);
            st_chk(32'h0);
         end
      end
      // End of integration flags only in line-cycle mode.
      for (int m = 0; m < 2; m++) begin
         @(negedge clk_sys_i);
         lc_mode = m[0];
         lc_end  = 1'b1;
         @(negedge clk_sys_i);
         lc_end = 1'b0;
         settle();
         st_chk({26'h0, m[0], 5'h00});
         clr();
      end
      // Sign flips from the selected source only, with the sign register.
      for (int s = 0; s < 2; s++) begin
         acc = {s[0], s[0], 6'h00};
         settle();
         clr();
         st_chk(32'h0);
         for (int p = 0; p < 3; p++) begin
            asg[s ? p : 3+p] = ~asg[s ? p : 3+p];
            rsg[s ? p : 3+p] = ~rsg[s ? p : 3+p];
            sum1 = ~sum1;
            settle();
            st_chk(flip_word(p));
            chk({25'h0, sgn}, {25'h0, (s ? rsg.fund : rsg.total), sum1,
               (s ? asg.fund : asg.total)});
            clr();
            asg[s ? 3+p : p] = ~asg[s ? 3+p : p];
            rsg[s ? 3+p : p] = ~rsg[s ? 3+p : p];
            settle();
            st_chk(32'h0);
         end
      end
      // A new event in the cycle of a clear keeps the flag set.
      en[0][94] = ~en[0][94];
      settle();
      fork
         host.write(OFS_STATUS_FIRST, 32'h1);
         begin
            @(negedge clk_sys_i);
            en[0][94] = ~en[0][94];
         end
      join
      settle();
      st_chk(32'h1);
      // A second reset in mid-run clears the flags and the signs.
      @(negedge clk_sys_i);
      rst_b_i = 1'b0;
      for (int k = 0; k < 5; k++) en[k] = '0; // The accumulators clear with the device.
      @(negedge clk_sys_i);
      chk(status, 32'h0);
      chk({25'h0, sgn}, 32'h0);
      // Release again: the flags stay clear and the peak words read zero.
      rst_b_i = 1'b1;
      settle();
      st_chk(32'h0);
      rd_chk(OFS_CURRENT_PEAK, 32'h0);
      rd_chk(OFS_VOLTAGE_PEAK, 32'h0);
      tally_and_finish();
   end
endmodule // test_peak_and_status_flag_registers
